/* File: design/map_timer.sv */
// mapping window timer: open for a fixed cycle count, restartable.
// assumes the caller pulses i_start once per completed unlock.
`timescale 1ns/1ns
module map_timer #(
  parameter int CYCLES = sfr_pkg::MAP_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  output logic o_open
);
  logic [sfr_pkg::TMR_W-1:0] cnt_q;  // cycles still open
  // ****************************************************************
  // countdown; a new start reloads from the top
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_q <= '0;
    end else if (i_start) begin
      cnt_q <= sfr_pkg::TMR_W'(CYCLES);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;              // ends on its own
    end
  end
  // window open while counting
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_open <= 1'b0;
    end else begin
      o_open <= i_start || (cnt_q != '0);  // open for the loaded count plus one cycle
    end
  end
  a_timer_restart: assert property (@(posedge i_clk) disable iff (i_rst)
    i_start |=> cnt_q == sfr_pkg::TMR_W'(CYCLES))
    else $error("timer did not reload");
endmodule

/* File: design/sfr_indirect.sv */
// special-function register block: indirect ports, pointers, pc low, table, option map.
// assumes the core issues at most one data access per cycle, one instruction per cycle,
// and a program memory that answers a table read combinationally.
`timescale 1ns/1ns
module sfr_indirect (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_CYCLE,               // one pulse per instruction cycle
  input wire sfr_pkg::mem_req_t I_REQ,    // data access from the core
  input wire logic [7:0] I_RAM_RDATA,     // general data memory read data
  input wire logic [7:0] I_ALU_RESULT,    // alu output
  input wire logic I_ALU_WE,              // load alu output into accumulator
  input wire logic I_WAKE,                // wake from idle or sleep
  input wire logic I_TBL_RD,              // table read request
  input wire logic I_TBL_LAST,            // 1: last-page variant of table read
  input wire logic [15:0] I_PROG_WORD,    // program word at o_prog_addr
  input wire logic [15:0] I_OPT_WORD,     // option word at o_opt_addr
  output sfr_pkg::ram_port_t O_RAM,       // redirected access to data memory
  output logic [7:0] O_RDATA,             // read data to the core
  output logic [7:0] O_ACC,
  output logic O_PC_LOAD,                 // pc jump pulse
  output logic [sfr_pkg::PC_W-1:0] O_PC,
  output logic O_DUMMY,                   // one cycle stall after pc low write
  output logic [sfr_pkg::PC_W-1:0] O_PROG_ADDR,
  output logic [5:0] O_OPT_ADDR,
  output logic [7:0] O_TBL_LOW_DATA,      // low table byte to destination
  output logic O_TBL_DONE,
  output logic O_MAP_OPEN
);
  // ****************************************************************
  // storage
  // ****************************************************************
  logic [7:0] ptr_s0_q, ptr_a_low_q, ptr_a_sec_q, ptr_b_low_q, ptr_b_sec_q;
  logic [7:0] tbl_low_q, tbl_high_q, tbl_data_hi_q, unlock_q, acc_q;
  logic [sfr_pkg::PC_W-1:0] pc_q;
  logic armed_q;         // 55 seen in the previous instruction cycle
  logic unlock_pulse;    // completed pattern this cycle
  logic map_open;
  logic is_s0;
  localparam int SEC_W_F = sfr_pkg::SEC_W;
  // special registers live in sector 0 only; other sectors pass to ram
  function automatic logic hit(input logic [SEC_W_F-1:0] sec, input logic [7:0] a,
                               input logic [7:0] want);
    hit = (sec == '0) && (a == want);
  endfunction
  // ****************************************************************
  // effective address resolution
  // ****************************************************************
  sfr_pkg::ram_port_t eff;
  logic eff_special;     // effective target is itself a special register
  always_comb begin
    eff.we = I_REQ.wr;
    eff.sec = I_REQ.sec;     // extended direct: sector from upper bits
    eff.addr = I_REQ.addr;
    eff.wdata = I_REQ.wdata;
    if (hit(I_REQ.sec, I_REQ.addr, sfr_pkg::ADDR_IND_S0)) begin
      eff.sec = '0;
      eff.addr = ptr_s0_q;
    end else if (hit(I_REQ.sec, I_REQ.addr, sfr_pkg::ADDR_IND_A)) begin
      eff.sec = ptr_a_sec_q[SEC_W_F-1:0];
      eff.addr = ptr_a_low_q;
    end else if (hit(I_REQ.sec, I_REQ.addr, sfr_pkg::ADDR_IND_B)) begin
      eff.sec = ptr_b_sec_q[SEC_W_F-1:0];
      eff.addr = ptr_b_low_q;
    end
    // an indirect port pointing at an indirect port hits nothing real
    is_s0 = (eff.sec == '0);
    eff_special = is_s0 && (eff.addr < 8'h10 || eff.addr == sfr_pkg::ADDR_OPT_UNLOCK);
  end
  wire wr_en = I_REQ.wr;
  function automatic logic eff_is(input logic [7:0] want);
    eff_is = (eff.sec == '0) && (eff.addr == want);
  endfunction
  // ****************************************************************
  // pointer registers, plain read-write storage
  // ****************************************************************
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      ptr_s0_q <= sfr_pkg::RESET_BYTE;
      ptr_a_low_q <= sfr_pkg::RESET_BYTE;
      ptr_a_sec_q <= sfr_pkg::RESET_BYTE;
      ptr_b_low_q <= sfr_pkg::RESET_BYTE;
      ptr_b_sec_q <= sfr_pkg::RESET_BYTE;
    end else if (wr_en) begin
      if (eff_is(sfr_pkg::ADDR_PTR_S0)) ptr_s0_q <= eff.wdata;
      if (eff_is(sfr_pkg::ADDR_PTR_A_LOW)) ptr_a_low_q <= eff.wdata;
      if (eff_is(sfr_pkg::ADDR_PTR_A_SEC)) ptr_a_sec_q <= eff.wdata;
      if (eff_is(sfr_pkg::ADDR_PTR_B_LOW)) ptr_b_low_q <= eff.wdata;
      if (eff_is(sfr_pkg::ADDR_PTR_B_SEC)) ptr_b_sec_q <= eff.wdata;
    end
  end
  // ****************************************************************
  // accumulator: alu results land here, else plain write
  // ****************************************************************
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      acc_q <= sfr_pkg::RESET_BYTE;
    end else if (I_ALU_WE) begin
      acc_q <= I_ALU_RESULT;
    end else if (wr_en && eff_is(sfr_pkg::ADDR_ACC)) begin
      acc_q <= eff.wdata;
    end
  end
  // ****************************************************************
  // program counter low: in-page jump plus dummy cycle
  // ****************************************************************
  wire pc_wr = wr_en && eff_is(sfr_pkg::ADDR_PC_LOW);
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      pc_q <= '0;
      O_PC_LOAD <= 1'b0;
      O_DUMMY <= 1'b0;
    end else begin
      O_PC_LOAD <= pc_wr;
      O_DUMMY <= pc_wr;                       // one stall cycle
      if (pc_wr) begin
        pc_q <= {pc_q[sfr_pkg::PC_W-1:8], eff.wdata};  // page kept
      end
    end
  end
  assign O_PC = pc_q;
  // ****************************************************************
  // table pointers and table read
  // ****************************************************************
  logic in_window;
  logic [sfr_pkg::PC_W-1:0] tbl_addr;
  always_comb begin
    // last-page variant forces the page bits high; paged uses the high pointer
    if (I_TBL_LAST) begin
      tbl_addr = {{(sfr_pkg::PC_W-8){1'b1}}, tbl_low_q};
    end else begin
      tbl_addr = {tbl_high_q[sfr_pkg::PC_W-9:0], tbl_low_q};
    end
    in_window = map_open && (tbl_addr[sfr_pkg::PC_W-1:8] == '1)
                && (tbl_low_q >= sfr_pkg::OPT_BASE);
  end
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      tbl_low_q <= sfr_pkg::RESET_BYTE;
      tbl_high_q <= sfr_pkg::RESET_BYTE;
    end else if (wr_en) begin
      if (eff_is(sfr_pkg::ADDR_TBL_LOW)) tbl_low_q <= eff.wdata;
      if (eff_is(sfr_pkg::ADDR_TBL_HIGH)) tbl_high_q <= eff.wdata;
    end
  end
  // option memory substitutes for C0..FF of the last page while open
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      tbl_data_hi_q <= sfr_pkg::RESET_BYTE;
      O_TBL_LOW_DATA <= sfr_pkg::RESET_BYTE;
      O_TBL_DONE <= 1'b0;
    end else begin
      O_TBL_DONE <= I_TBL_RD;
      if (I_TBL_RD) begin
        if (in_window) begin
          tbl_data_hi_q <= I_OPT_WORD[15:8];
          O_TBL_LOW_DATA <= I_OPT_WORD[7:0];
        end else begin
          tbl_data_hi_q <= I_PROG_WORD[15:8];
          O_TBL_LOW_DATA <= I_PROG_WORD[7:0];
        end
      end else if (wr_en && eff_is(sfr_pkg::ADDR_TBL_DATA_HI)) begin
        tbl_data_hi_q <= eff.wdata;
      end
    end
  end
  always_comb begin
    O_PROG_ADDR = tbl_addr;
    O_OPT_ADDR = tbl_low_q[5:0];              // C0..FF maps to 00..3F
  end
  // ****************************************************************
  // option map unlock sequence
  // ****************************************************************
  wire unl_wr = wr_en && eff_is(sfr_pkg::ADDR_OPT_UNLOCK);
  assign unlock_pulse = I_CYCLE && armed_q && unl_wr
                        && (eff.wdata == sfr_pkg::UNLOCK_SECOND);
  always_ff @(posedge I_CLK) begin
    if (I_RST || I_WAKE) begin
      unlock_q <= sfr_pkg::RESET_BYTE;        // cleared on wake
    end else if (unl_wr) begin
      unlock_q <= eff.wdata;
    end
  end
  // armed only for the one instruction cycle after 55
  always_ff @(posedge I_CLK) begin
    if (I_RST || I_WAKE) begin
      armed_q <= 1'b0;
    end else if (I_CYCLE) begin
      armed_q <= unl_wr && (eff.wdata == sfr_pkg::UNLOCK_FIRST);
    end
  end
  map_timer #(.CYCLES(sfr_pkg::MAP_CYCLES)) u_timer (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_start(unlock_pulse),
    .o_open(map_open)
  );
  always_ff @(posedge I_CLK) begin
    if (I_RST) O_MAP_OPEN <= 1'b0;
    else O_MAP_OPEN <= map_open;
  end
  // ****************************************************************
  // read mux and ram port
  // ****************************************************************
  logic ram_rd_q;          // previous access targeted general ram
  logic [7:0] sp_rdata_q;  // special register value of the previous access
  // ram answers for the registered port one cycle later, so every read returns
  // two edges after it is taken; special reads are delayed to keep one latency
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_RDATA <= sfr_pkg::RESET_BYTE;
      O_RAM <= '0;
      ram_rd_q <= 1'b0;
      sp_rdata_q <= sfr_pkg::RESET_BYTE;
    end else begin
      O_RAM <= eff;
      O_RAM.we <= wr_en && !eff_special;      // ports themselves store nothing
      ram_rd_q <= !eff_special;               // pointed location answers
      O_RDATA <= ram_rd_q ? I_RAM_RDATA : sp_rdata_q;
      if (!eff_special) sp_rdata_q <= sfr_pkg::READ_EMPTY;
      else if (eff_is(sfr_pkg::ADDR_PTR_S0)) sp_rdata_q <= ptr_s0_q;
      else if (eff_is(sfr_pkg::ADDR_PTR_A_LOW)) sp_rdata_q <= ptr_a_low_q;
      else if (eff_is(sfr_pkg::ADDR_PTR_A_SEC)) sp_rdata_q <= ptr_a_sec_q;
      else if (eff_is(sfr_pkg::ADDR_PTR_B_LOW)) sp_rdata_q <= ptr_b_low_q;
      else if (eff_is(sfr_pkg::ADDR_PTR_B_SEC)) sp_rdata_q <= ptr_b_sec_q;
      else if (eff_is(sfr_pkg::ADDR_ACC)) sp_rdata_q <= acc_q;
      else if (eff_is(sfr_pkg::ADDR_PC_LOW)) sp_rdata_q <= pc_q[7:0];
      else if (eff_is(sfr_pkg::ADDR_TBL_LOW)) sp_rdata_q <= tbl_low_q;
      else if (eff_is(sfr_pkg::ADDR_TBL_HIGH)) sp_rdata_q <= tbl_high_q;
      else if (eff_is(sfr_pkg::ADDR_TBL_DATA_HI)) sp_rdata_q <= tbl_data_hi_q;
      else if (eff_is(sfr_pkg::ADDR_OPT_UNLOCK)) sp_rdata_q <= unlock_q;
      else sp_rdata_q <= sfr_pkg::READ_EMPTY; // indirect port reads zero
    end
  end
  assign O_ACC = acc_q;
  // ****************************************************************
  // checks
  // ****************************************************************
  a_unlock_pair: assert property (@(posedge I_CLK) disable iff (I_RST)
    unlock_pulse |-> $past(unl_wr) && ($past(eff.wdata) == sfr_pkg::UNLOCK_FIRST))
    else $error("unlock without preceding first byte");
  a_pc_page: assert property (@(posedge I_CLK) disable iff (I_RST)
    pc_wr |=> O_PC[sfr_pkg::PC_W-1:8] == $past(pc_q[sfr_pkg::PC_W-1:8]))
    else $error("pc low write left the page");
  a_dummy_cycle: assert property (@(posedge I_CLK) disable iff (I_RST)
    pc_wr |=> O_DUMMY)
    else $error("no dummy cycle after jump");
  a_wake_clear: assert property (@(posedge I_CLK) disable iff (I_RST)
    I_WAKE |=> unlock_q == sfr_pkg::RESET_BYTE && !armed_q)
    else $error("unlock not cleared on wake");
  a_map_ends: assert property (@(posedge I_CLK) disable iff (I_RST)
    !map_open && !unlock_pulse |=> !map_open)
    else $error("map opened without unlock");
  a_s0_sector: assert property (@(posedge I_CLK) disable iff (I_RST)
    I_REQ.rd && hit(I_REQ.sec, I_REQ.addr, sfr_pkg::ADDR_IND_S0) |=> O_RAM.sec == '0)
    else $error("sector-0 port left sector 0");
  a_acc_alu: assert property (@(posedge I_CLK) disable iff (I_RST)
    I_ALU_WE |=> acc_q == $past(I_ALU_RESULT))
    else $error("alu result not in accumulator");
  a_tbl_high: assert property (@(posedge I_CLK) disable iff (I_RST)
    I_TBL_RD && !in_window |=> tbl_data_hi_q == $past(I_PROG_WORD[15:8]))
    else $error("table high byte wrong");
endmodule

/* File: design/sfr_pkg.sv */
// package for the special-function register block: addresses, patterns, timing.
// assumes a single 100 MHz clock and a core that issues one data access per cycle.
package sfr_pkg;
  // ****************************************************************
  // data-memory addresses (sector 0 special registers)
  // ****************************************************************
  localparam logic [7:0] ADDR_IND_S0 = 8'h00;  // indirect port, sector 0 only
  localparam logic [7:0] ADDR_PTR_S0 = 8'h01;
  localparam logic [7:0] ADDR_IND_A = 8'h02;
  localparam logic [7:0] ADDR_PTR_A_LOW = 8'h03;
  localparam logic [7:0] ADDR_PTR_A_SEC = 8'h04;
  localparam logic [7:0] ADDR_ACC = 8'h05;
  localparam logic [7:0] ADDR_PC_LOW = 8'h06;
  localparam logic [7:0] ADDR_TBL_LOW = 8'h07;
  localparam logic [7:0] ADDR_TBL_DATA_HI = 8'h08;
  localparam logic [7:0] ADDR_TBL_HIGH = 8'h09;
  localparam logic [7:0] ADDR_IND_B = 8'h0C;
  localparam logic [7:0] ADDR_PTR_B_LOW = 8'h0D;
  localparam logic [7:0] ADDR_PTR_B_SEC = 8'h0E;
  localparam logic [7:0] ADDR_OPT_UNLOCK = 8'h40;  // sector 0 only
  // ****************************************************************
  // widths, patterns, reset values
  // ****************************************************************
  localparam int SEC_W = 2;                      // sector field width
  localparam int PC_W = 13;                      // program counter width
  localparam int OPT_WORDS = 64;                 // option memory depth
  localparam logic [7:0] UNLOCK_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND = 8'hAA;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] READ_EMPTY = 8'h00;     // read of an indirect port
  localparam logic [7:0] OPT_BASE = 8'hC0;       // last-page window start
  // ****************************************************************
  // timing: four low-speed oscillator periods
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int LOW_SPEED_INTERNAL_OSCILLATOR_PERIOD_NS = 31250;         // 32 kHz oscillator period
  localparam int MAP_PERIODS = 4;
  localparam int MAP_CYCLES = (MAP_PERIODS * LOW_SPEED_INTERNAL_OSCILLATOR_PERIOD_NS) / CLK_PERIOD_NS;
  localparam int TMR_W = 14;
  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic rd;            // data read strobe
    logic wr;            // data write strobe
    logic [SEC_W-1:0] sec;  // sector for extended direct access
    logic [7:0] addr;    // in-sector address
    logic [7:0] wdata;
  } mem_req_t;
  typedef struct packed {
    logic we;
    logic [SEC_W-1:0] sec;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ram_port_t;
endpackage

/* File: tb/sfr_indirect_tb.sv */
// self-checking bench of the special-function register block.
// assumes one instruction per cycle, so the instruction-cycle input is held high.
`timescale 1ns/1ns
module sfr_indirect_tb;
  // ****************************************************************
  // stimulus and observed nets
  // ****************************************************************
  logic I_CLK = 1'b0;
  logic I_RST = 1'b1;
  logic I_CYCLE = 1'b1;                 // every clock is an instruction cycle
  sfr_pkg::mem_req_t I_REQ = '0;
  logic [7:0] I_ALU_RESULT = 8'h00;
  logic I_ALU_WE = 1'b0;
  logic I_WAKE = 1'b0;
  logic I_TBL_RD = 1'b0;
  logic I_TBL_LAST = 1'b0;
  logic [7:0] I_RAM_RDATA;
  logic [15:0] I_PROG_WORD;
  logic [15:0] I_OPT_WORD;
  sfr_pkg::ram_port_t O_RAM;
  logic [7:0] O_RDATA;
  logic [7:0] O_ACC;
  logic O_PC_LOAD;
  logic [sfr_pkg::PC_W-1:0] O_PC;
  logic O_DUMMY;
  logic [sfr_pkg::PC_W-1:0] O_PROG_ADDR;
  logic [5:0] O_OPT_ADDR;
  logic [7:0] O_TBL_LOW_DATA;
  logic O_TBL_DONE;
  logic O_MAP_OPEN;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  int t0;
  integer seed = 32'hDBDDF44B;
  int ptr [5];                          // bench copy of the five pointer bytes
  logic [7:0] paddr [5];
  logic [7:0] d;
  sfr_indirect sfr_indirect_i (.I_CLK(I_CLK), .I_RST(I_RST), .I_CYCLE(I_CYCLE), .I_REQ(I_REQ),
    .I_RAM_RDATA(I_RAM_RDATA), .I_ALU_RESULT(I_ALU_RESULT), .I_ALU_WE(I_ALU_WE),
    .I_WAKE(I_WAKE), .I_TBL_RD(I_TBL_RD), .I_TBL_LAST(I_TBL_LAST), .I_PROG_WORD(I_PROG_WORD),
    .I_OPT_WORD(I_OPT_WORD), .O_RAM(O_RAM), .O_RDATA(O_RDATA), .O_ACC(O_ACC),
    .O_PC_LOAD(O_PC_LOAD), .O_PC(O_PC), .O_DUMMY(O_DUMMY), .O_PROG_ADDR(O_PROG_ADDR),
    .O_OPT_ADDR(O_OPT_ADDR), .O_TBL_LOW_DATA(O_TBL_LOW_DATA), .O_TBL_DONE(O_TBL_DONE),
    .O_MAP_OPEN(O_MAP_OPEN));
  sfr_mem_model sfr_mem_model_i (.i_clk(I_CLK), .i_ram(O_RAM), .o_ram_rdata(I_RAM_RDATA),
    .i_prog_addr(O_PROG_ADDR), .o_prog_word(I_PROG_WORD), .i_opt_addr(O_OPT_ADDR),
    .o_opt_word(I_OPT_WORD));
  // ****************************************************************
  // clock and hang guard
  // ****************************************************************
  always #5 I_CLK = ~I_CLK;
  // four mapping windows plus margin; a hang past this is a failure
  always @(posedge I_CLK) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      complete_run();
    end
  end
  // ****************************************************************
  // reference images and helpers
  // ****************************************************************
  function automatic logic [15:0] exp_prog(input logic [12:0] a);
    return {a[7:0] ^ 8'h3C, 3'h0, a[12:8]};
  endfunction
  function automatic logic [15:0] exp_opt(input logic [5:0] a);
    return {~a, 4'h6, a};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one data access; held until the next call so back-to-back needs no gap
  task automatic op(input logic rd, input logic wr, input logic [1:0] s, input logic [7:0] a,
                    input logic [7:0] w);
    I_REQ = '{rd: rd, wr: wr, sec: s, addr: a, wdata: w};
    @(posedge I_CLK);
    #1;
  endtask
  task automatic idle();
    op(1'b0, 1'b0, 2'd0, 8'h00, 8'h00);
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] w);
    op(1'b0, 1'b1, 2'd0, a, w);
  endtask
  // read data stands two edges after the request is taken
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    op(1'b1, 1'b0, 2'd0, a, 8'h00);
    @(posedge I_CLK);
    #1;
    check(32'(O_RDATA), 32'(exp));
  endtask
  // table read with the expected word worked out from pointers and window state
  task automatic tbl(input logic last, input logic [7:0] hi, input logic [7:0] lo,
                     input logic open);
    logic [12:0] pa;
    logic [15:0] w;
    pa = {(last ? 5'h1F : hi[4:0]), lo};
    w = (open && pa[12:8] == 5'h1F && lo >= sfr_pkg::OPT_BASE) ?
        exp_opt(6'(lo - sfr_pkg::OPT_BASE)) : exp_prog(pa);
    wr8(sfr_pkg::ADDR_TBL_LOW, lo);
    wr8(sfr_pkg::ADDR_TBL_HIGH, hi);
    idle();
    I_TBL_LAST = last;
    I_TBL_RD = 1'b1;
    @(posedge I_CLK);
    #1;
    I_TBL_RD = 1'b0;
    check(32'(O_TBL_DONE), 32'h1);
    check(32'(O_TBL_LOW_DATA), 32'(w[7:0]));
    rd_chk(sfr_pkg::ADDR_TBL_DATA_HI, w[15:8]);
  endtask
  // measure the open window from the unlocking edge until it shuts
  task automatic window_len();
    t0 = cycles;
    while (O_MAP_OPEN !== 1'b0 && cycles - t0 < 20000) begin
      @(posedge I_CLK);
      #1;
    end
    check(32'(cycles - t0 >= sfr_pkg::MAP_CYCLES && cycles - t0 <= sfr_pkg::MAP_CYCLES + 3),
          32'h1);
  endtask
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    paddr = '{sfr_pkg::ADDR_PTR_S0, sfr_pkg::ADDR_PTR_A_LOW, sfr_pkg::ADDR_PTR_A_SEC,
              sfr_pkg::ADDR_PTR_B_LOW, sfr_pkg::ADDR_PTR_B_SEC};
    repeat (5) @(posedge I_CLK);
    #1 I_RST = 1'b0;
    @(posedge I_CLK);
    #1;
    rd_chk(sfr_pkg::ADDR_OPT_UNLOCK, 8'h00);
    // pointers: random values, low bytes kept clear of the special area
    for (int i = 0; i < 5; i++) begin
      ptr[i] = (i == 2 || i == 4) ? ($random(seed) & 3) : (8'h80 | ($random(seed) & 8'h3F));
      wr8(paddr[i], 8'(ptr[i]));
    end
    for (int i = 0; i < 5; i++) rd_chk(paddr[i], 8'(ptr[i]));
    ptr[1] = ptr[1] + 1;
    wr8(sfr_pkg::ADDR_PTR_A_LOW, 8'(ptr[1]));
    rd_chk(sfr_pkg::ADDR_PTR_A_LOW, 8'(ptr[1]));
    $display("test pointers done");
    // indirect writes land at the pointed location, port 0 pinned to sector 0
    d = 8'($random(seed));
    wr8(sfr_pkg::ADDR_IND_S0, d);
    check(32'(O_RAM), 32'({1'b1, 2'd0, 8'(ptr[0]), d}));
    wr8(sfr_pkg::ADDR_IND_A, ~d);
    check(32'(O_RAM), 32'({1'b1, 2'(ptr[2]), 8'(ptr[1]), ~d}));
    wr8(sfr_pkg::ADDR_IND_B, d ^ 8'h5A);
    check(32'(O_RAM), 32'({1'b1, 2'(ptr[4]), 8'(ptr[3]), d ^ 8'h5A}));
    // sector 1 location 40H through port a, then read back from ram
    wr8(sfr_pkg::ADDR_PTR_A_LOW, 8'h40);
    wr8(sfr_pkg::ADDR_PTR_A_SEC, 8'h01);
    wr8(sfr_pkg::ADDR_IND_A, d);
    check(32'(O_RAM), 32'({1'b1, 2'd1, 8'h40, d}));
    rd_chk(sfr_pkg::ADDR_IND_A, d);
    op(1'b0, 1'b1, 2'd1, 8'hF0, d);
    check(32'(O_RAM), 32'({1'b1, 2'd1, 8'hF0, d}));
    // pointer aimed at a port: write does nothing, read gives zero
    wr8(sfr_pkg::ADDR_PTR_S0, sfr_pkg::ADDR_IND_S0);
    wr8(sfr_pkg::ADDR_IND_S0, 8'hFF);
    check(32'(O_RAM.we), 32'h0);
    rd_chk(sfr_pkg::ADDR_IND_S0, sfr_pkg::READ_EMPTY);
    $display("test indirect done");
    // alu load wins over a register write in the same cycle
    I_ALU_RESULT = 8'($random(seed));
    I_ALU_WE = 1'b1;
    wr8(sfr_pkg::ADDR_ACC, ~I_ALU_RESULT);
    I_ALU_WE = 1'b0;
    check(32'(O_ACC), 32'(I_ALU_RESULT));
    rd_chk(sfr_pkg::ADDR_ACC, I_ALU_RESULT);
    // pc low write: jump inside page 0 and one dummy cycle, both single pulses
    wr8(sfr_pkg::ADDR_PC_LOW, d);
    check(32'({O_PC_LOAD, O_DUMMY, O_PC}), 32'({2'b11, 5'h00, d}));
    idle();
    check(32'({O_PC_LOAD, O_DUMMY}), 32'h0);
    $display("test acc and pc done");
    // plain table reads, both variants, window shut
    tbl(1'b0, 8'($random(seed)) & 8'h1F, 8'($random(seed)), 1'b0);
    tbl(1'b1, 8'h03, 8'hC5, 1'b0);
    // broken pattern and wake clearing
    wr8(sfr_pkg::ADDR_OPT_UNLOCK, sfr_pkg::UNLOCK_FIRST);
    rd_chk(sfr_pkg::ADDR_OPT_UNLOCK, sfr_pkg::UNLOCK_FIRST);
    wr8(sfr_pkg::ADDR_OPT_UNLOCK, sfr_pkg::UNLOCK_SECOND);
    repeat (3) idle();
    check(32'(O_MAP_OPEN), 32'h0);
    wr8(sfr_pkg::ADDR_OPT_UNLOCK, sfr_pkg::UNLOCK_FIRST);
    I_WAKE = 1'b1;
    idle();
    I_WAKE = 1'b0;
    rd_chk(sfr_pkg::ADDR_OPT_UNLOCK, 8'h00);
    $display("test table and refusal done");
    // proper unlock, mapped reads, restart, then timed close
    // the two writes go back to back, nothing may come between them
    wr8(sfr_pkg::ADDR_OPT_UNLOCK, sfr_pkg::UNLOCK_FIRST);
    wr8(sfr_pkg::ADDR_OPT_UNLOCK, sfr_pkg::UNLOCK_SECOND);
    idle();
    idle();
    check(32'(O_MAP_OPEN), 32'h1);
    tbl(1'b1, 8'h00, 8'hC0 | 8'($random(seed) & 8'h3F), 1'b1);
    tbl(1'b0, 8'h1F, 8'hFF, 1'b1);
    tbl(1'b1, 8'h00, 8'hBF, 1'b1);
    repeat (3000) @(posedge I_CLK);
    #1;
    wr8(sfr_pkg::ADDR_OPT_UNLOCK, sfr_pkg::UNLOCK_FIRST);
    wr8(sfr_pkg::ADDR_OPT_UNLOCK, sfr_pkg::UNLOCK_SECOND);
    window_len();
    tbl(1'b1, 8'h00, 8'hC1, 1'b0);
    $display("test option window done");
    complete_run();
  end
endmodule

/* File: tb/sfr_mem_model.sv */
// far-side memories of the block: general data ram, program memory, option memory.
// assumes the block drives one registered ram port and reads both rom images combinationally.
`timescale 1ns/1ns
module sfr_mem_model (
  input wire logic i_clk,
  input wire sfr_pkg::ram_port_t i_ram,                // redirected access from the block
  output logic [7:0] o_ram_rdata,
  input wire logic [sfr_pkg::PC_W-1:0] i_prog_addr,
  output logic [15:0] o_prog_word,
  input wire logic [5:0] i_opt_addr,
  output logic [15:0] o_opt_word
);
  // ****************************************************************
  // data ram, every sector, cleared at start so reads never float
  // ****************************************************************
  logic [7:0] ram_q [1024];
  initial begin
    foreach (ram_q[k]) ram_q[k] = 8'h00;
  end
  // store only when the block says the target is real memory
  always @(posedge i_clk) begin
    if (i_ram.we) begin
      ram_q[{i_ram.sec, i_ram.addr}] <= i_ram.wdata;
    end
  end
  assign o_ram_rdata = ram_q[{i_ram.sec, i_ram.addr}];
  // ****************************************************************
  // rom images: patterns differ per address, so a wrong pointer shows
  // ****************************************************************
  assign o_prog_word = {i_prog_addr[7:0] ^ 8'h3C, 3'h0, i_prog_addr[12:8]};
  assign o_opt_word = {~i_opt_addr, 4'h6, i_opt_addr};
endmodule
